// *** rtl/two_entry_buffer.sv ***
// Purpose: Two-entry valid/ready buffer on the read data path
// Assumes: Synchronous active-high reset
// Notes: All outputs registered; ready drops only when both slots hold
`timescale 1ns/100ps
module two_entry_buffer (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic srst_in,
  // Fill side
  input wire logic in_valid_in,
  input wire usb_cmd_pkg::byte_t in_data_in,
  output logic in_ready_out,
  // Drain side
  output logic out_valid_out,
  output usb_cmd_pkg::byte_t out_data_out,
  input wire logic out_ready_in
);
  import usb_cmd_pkg::*;

  logic [1:0] count;
  logic [1:0] next_count;
  byte_t slot1;
  logic push;
  logic pop;

  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 2'h1;
    end else if (pop && !push) begin
      next_count = count - 2'h1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      count <= 2'h0;
      in_ready_out <= 1'b1;
      out_valid_out <= 1'b0;
    end else begin
      count <= next_count;
      in_ready_out <= (next_count != 2'h2);
      out_valid_out <= (next_count != 2'h0);
    end
  end

  // Slot 0 always presents the oldest word
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      out_data_out <= 8'h00;
      slot1 <= 8'h00;
    end else begin
      if (pop) begin
        out_data_out <= (count == 2'h2) ? slot1 : in_data_in;
      end else if (push && count == 2'h0) begin
        out_data_out <= in_data_in;
      end
      if (push && ((count == 2'h1 && !pop) || (count == 2'h2))) begin
        slot1 <= in_data_in;
      end
    end
  end

endmodule

// *** rtl/usb_cmd_cfg.svh ***
// Purpose: Constants for the endpoint command handler
// Assumes: 100 MHz core clock
// Notes: Codes, field positions, reset values and timing counts
`ifndef USB_CMD_CFG_SVH
`define USB_CMD_CFG_SVH

// ------------------------------------------------------------------
// Command codes
// ------------------------------------------------------------------
`define CMD_BUFFER 8'hf0
`define CMD_ACK_SETUP 8'hf1
`define CMD_CLEAR_BUF 8'hf2
`define CMD_VALIDATE 8'hfa
`define CMD_READ_IRQ 8'hf4
`define CMD_FRAME 8'hf5
`define CMD_RESUME 8'hf6
`define CMD_BUF_IRQ_MODE 8'hec
`define CMD_GRP_SELECT 4'h0
`define CMD_GRP_EP_STAT 4'h4
`define CMD_GRP_EP_BUF 4'h8
`define EP_LAST_DEFAULT 4'h5

// ------------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------------
`define STALL_WR_BIT 0
`define SEL_FULL_BIT 0
`define SEL_STALL_BIT 1
`define EBS_SETUP_BIT 2
`define EBS_FULL_BIT 5
`define EBS_STALL_BIT 7
`define STALL_RESET 16'h0000
`define FULL_RESET 16'h0000
`define FRAME_RESET 11'h000
`define PTR_START 7'h00
`define CTRL_OUT_EP 4'h0
`define CTRL_IN_EP 4'h1

// ------------------------------------------------------------------
// Timing and counts
// ------------------------------------------------------------------
`define CLK_FREQ_KHZ 100000
`define RESUME_MS 10
`define PRIME_BYTES_DEFAULT 3'h2
`define PRIME_BYTES_ENHANCED 3'h4

`endif

// *** rtl/usb_cmd_pkg.sv ***
// Purpose: Types for the endpoint command handler
// Assumes: Constants come from usb_cmd_cfg.svh
// Notes: One-hot command phase encoding
package usb_cmd_pkg;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_BUF   = 7'h02,
    ST_SEL   = 7'h04,
    ST_EPST  = 7'h08,
    ST_ESTAT = 7'h10,
    ST_IRQ   = 7'h20,
    ST_FRAME = 7'h40
  } phase_e;

  typedef logic [7:0] byte_t;
  typedef logic [3:0] ep_t;

endpackage

// *** rtl/usb_endpoint_command_handler.sv ***
// Purpose: Command-port handling for a full-speed USB device controller
// Assumes: Packet engine fills OUT buffers and drains IN buffers
// Notes: Endpoint index even = OUT, odd = IN; 128 bytes per buffer
// Operation
// R01: Read buffer returns selected OUT buffer bytes
// R02: Layout: length high, length low, payload
// R03: MCU writes IN packet, length high zero
// R04: Clear buffer frees the OUT buffer
// R05: Validate buffer marks IN buffer full
// R06: Set endpoint status bit 0 sets stall
// R07: SETUP clears control endpoint zero stall
// R08: Stall cleared flushes buffer, next PID DATA0
// R09: SETUP flushes IN, locks validate and clear
// R10: Acknowledge setup on both endpoints unlocks
// R11: Frame number read: low byte, high bits
// R12: Send resume while suspended drives 10 ms
// R13: MCU wakes clocks before sending resume
// R14: Interrupt reads may pause buffer transfer
// R15: Default mode primes after two interrupt bytes
// R16: Buffer interrupt mode primes after four
// R17: Buffer status bit 7 shows stall
// R18: Select endpoint picks target endpoint
// R19: New buffer command restarts pointer
`timescale 1ns/100ps
`include "usb_cmd_cfg.svh"
module usb_endpoint_command_handler #(
  parameter int RESUME_CYCLES = `RESUME_MS * `CLK_FREQ_KHZ
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic srst_in,
  // Microcontroller command port
  input wire logic req_valid_in,
  input wire logic req_cmd_in,
  input wire logic req_write_in,
  input wire usb_cmd_pkg::byte_t req_data_in,
  output logic req_ready_out,
  output logic rd_valid_out,
  output usb_cmd_pkg::byte_t rd_data_out,
  input wire logic rd_ready_in,
  // Device state
  input wire logic enhanced_mode_in,
  input wire logic suspended_in,
  input wire logic [31:0] irq_reg_in,
  // Packet engine
  input wire logic usb_setup_in,
  input wire logic usb_sof_in,
  input wire logic [10:0] usb_frame_in,
  input wire logic usb_wr_in,
  input wire usb_cmd_pkg::ep_t usb_wr_ep_in,
  input wire logic [6:0] usb_wr_addr_in,
  input wire usb_cmd_pkg::byte_t usb_wr_data_in,
  input wire logic usb_rx_done_in,
  input wire logic usb_tx_done_in,
  input wire usb_cmd_pkg::ep_t usb_ep_in,
  input wire logic [6:0] usb_rd_addr_in,
  output usb_cmd_pkg::byte_t usb_rd_data_out,
  output logic [15:0] buf_full_out,
  output logic [15:0] stall_out,
  output logic [15:0] data0_reset_out,
  output logic resume_out
);
  import usb_cmd_pkg::*;

  // ------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------
  phase_e phase;
  ep_t sel;
  logic [6:0] ptr;
  logic held;
  logic primed;
  logic buf_irq_mode;
  logic setup_lock;
  logic [1:0] ack_seen;
  logic setup_seen;
  logic [2:0] irq_cnt;
  logic [10:0] frame;
  logic frame_cnt;
  logic [31:0] resume_cnt;
  byte_t mem [0:2047];
  logic push_ready;
  logic take;
  logic take_cmd;
  logic take_rd;
  logic take_wr;
  logic buf_acc;
  ep_t cmd_ep;
  logic ep_ok;
  logic ctrl_sel;
  logic in_xfer;
  logic [2:0] prime_cnt;
  byte_t push_data;
  byte_t ebs_byte;

  assign req_ready_out = push_ready;
  assign take = req_valid_in & push_ready;
  assign take_cmd = take & req_cmd_in;
  assign take_rd = take & !req_cmd_in & !req_write_in;
  assign take_wr = take & !req_cmd_in & req_write_in;
  // A primed resumption turns the next data access into buffer access
  assign buf_acc = (take_rd | take_wr) & (phase == ST_BUF | primed); // see R14
  assign cmd_ep = req_data_in[3:0];
  assign ep_ok = enhanced_mode_in | (cmd_ep <= `EP_LAST_DEFAULT);
  assign ctrl_sel = (sel == `CTRL_OUT_EP) | (sel == `CTRL_IN_EP);
  assign in_xfer = (phase == ST_BUF) | held;
  assign prime_cnt = buf_irq_mode ? `PRIME_BYTES_ENHANCED // see R16
                                  : `PRIME_BYTES_DEFAULT; // see R15

  // Status byte for the endpoint buffer status read
  always_comb begin
    ebs_byte = 8'h00;
    ebs_byte[`EBS_STALL_BIT] = stall_out[sel]; // see R17
    ebs_byte[`EBS_FULL_BIT] = buf_full_out[sel];
    ebs_byte[`EBS_SETUP_BIT] = setup_seen & (sel == `CTRL_OUT_EP);
  end

  always_comb begin
    push_data = 8'h00;
    if (buf_acc) begin
      push_data = mem[{sel, ptr}]; // see R01
    end else begin
      case (phase)
        ST_SEL: begin
          push_data[`SEL_FULL_BIT] = buf_full_out[sel];
          push_data[`SEL_STALL_BIT] = stall_out[sel];
        end
        ST_ESTAT: push_data = ebs_byte;
        ST_IRQ: push_data = irq_reg_in[{irq_cnt[1:0], 3'h0} +: 8];
        ST_FRAME: begin
          // Upper five bits of the second byte read as zero
          push_data = frame_cnt ? {5'h00, frame[10:8]} // see R11
                                : frame[7:0];
        end
        default: push_data = 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Command phase and selection
  // ------------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      phase <= ST_IDLE;
      sel <= `CTRL_OUT_EP;
      buf_irq_mode <= 1'b0;
    end else if (take_cmd) begin
      phase <= ST_IDLE;
      if (req_data_in == `CMD_BUFFER) begin
        phase <= ST_BUF;
      end else if (req_data_in == `CMD_READ_IRQ) begin
        phase <= ST_IRQ;
      end else if (req_data_in == `CMD_FRAME) begin
        phase <= ST_FRAME;
      end else if (req_data_in == `CMD_BUF_IRQ_MODE) begin
        buf_irq_mode <= enhanced_mode_in;
      end else if (ep_ok) begin
        case (req_data_in[7:4])
          `CMD_GRP_SELECT: begin
            sel <= cmd_ep; // see R18
            phase <= ST_SEL;
          end
          `CMD_GRP_EP_STAT: begin
            sel <= cmd_ep;
            phase <= ST_EPST;
          end
          `CMD_GRP_EP_BUF: begin
            sel <= cmd_ep;
            phase <= ST_ESTAT;
          end
          default: phase <= ST_IDLE;
        endcase
      end
    end else if (buf_acc) begin
      phase <= ST_BUF;
    end
  end

  // ------------------------------------------------------------------
  // Buffer pointer and resumption
  // ------------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      ptr <= `PTR_START;
    end else if (take_cmd && req_data_in == `CMD_BUFFER && !primed) begin
      ptr <= `PTR_START; // see R19
    end else if (buf_acc) begin
      ptr <= ptr + 7'h01; // see R02
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      held <= 1'b0;
      primed <= 1'b0;
      irq_cnt <= 3'h0;
    end else if (take_cmd) begin
      // Only interrupt and status reads keep a paused transfer alive
      held <= in_xfer & ((req_data_in == `CMD_READ_IRQ) |
              (req_data_in[7:4] == `CMD_GRP_EP_STAT)); // see R14
      primed <= primed & (req_data_in == `CMD_BUFFER);
      irq_cnt <= 3'h0;
    end else if (buf_acc) begin
      held <= 1'b0;
      primed <= 1'b0;
    end else if (take_rd && phase == ST_IRQ) begin
      irq_cnt <= irq_cnt + 3'h1;
      if (held && (irq_cnt + 3'h1) == prime_cnt) begin
        primed <= 1'b1; // see R15
      end
    end else if (take_rd && phase == ST_EPST && held) begin
      primed <= 1'b1; // see R14
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      frame_cnt <= 1'b0;
    end else if (take_cmd) begin
      frame_cnt <= 1'b0;
    end else if (take_rd && phase == ST_FRAME) begin
      frame_cnt <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Buffer memory
  // ------------------------------------------------------------------
  // No reset on the array; contents are only meaningful once written
  always_ff @(posedge mclk_in) begin
    if (take_wr && buf_acc) begin
      mem[{sel, ptr}] <= req_data_in; // see R03
    end
    if (usb_wr_in) begin
      mem[{usb_wr_ep_in, usb_wr_addr_in}] <= usb_wr_data_in;
    end
    usb_rd_data_out <= mem[{usb_ep_in, usb_rd_addr_in}];
  end

  // ------------------------------------------------------------------
  // Full flags, stall and setup interlock
  // ------------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      buf_full_out <= `FULL_RESET;
    end else begin
      if (take_cmd && !(setup_lock && ctrl_sel)) begin // see R09
        if (req_data_in == `CMD_CLEAR_BUF) begin
          buf_full_out[sel] <= 1'b0; // see R04
        end else if (req_data_in == `CMD_VALIDATE) begin
          buf_full_out[sel] <= 1'b1; // see R05
        end
      end
      if (take_wr && phase == ST_EPST && !req_data_in[`STALL_WR_BIT]) begin
        buf_full_out[sel] <= 1'b0; // see R08
      end
      if (usb_tx_done_in) begin
        buf_full_out[usb_ep_in] <= 1'b0;
      end
      // Engine events win over a command in the same cycle
      if (usb_rx_done_in) begin
        buf_full_out[usb_ep_in] <= 1'b1;
      end
      if (usb_setup_in) begin
        buf_full_out[`CTRL_IN_EP] <= 1'b0; // see R09
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      stall_out <= `STALL_RESET;
      data0_reset_out <= 16'h0000;
    end else begin
      data0_reset_out <= 16'h0000;
      if (take_wr && phase == ST_EPST) begin
        stall_out[sel] <= req_data_in[`STALL_WR_BIT]; // see R06
        data0_reset_out[sel] <= !req_data_in[`STALL_WR_BIT]; // see R08
      end
      if (usb_setup_in) begin
        stall_out[`CTRL_OUT_EP] <= 1'b0; // see R07
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      setup_lock <= 1'b0;
      ack_seen <= 2'h0;
      setup_seen <= 1'b0;
    end else if (usb_setup_in) begin
      setup_lock <= 1'b1; // see R09
      ack_seen <= 2'h0;
      setup_seen <= 1'b1;
    end else if (take_cmd && req_data_in == `CMD_ACK_SETUP && ctrl_sel) begin
      // Lock lifts only after both control endpoints are acknowledged
      if ((ack_seen | (2'h1 << sel[0])) == 2'h3) begin
        setup_lock <= 1'b0; // see R10
        ack_seen <= 2'h0;
        setup_seen <= 1'b0;
      end else begin
        ack_seen <= ack_seen | (2'h1 << sel[0]);
      end
    end
  end

  // ------------------------------------------------------------------
  // Frame number and resume
  // ------------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      frame <= `FRAME_RESET;
    end else if (usb_sof_in) begin
      frame <= usb_frame_in; // see R11
    end
  end

  // Clock is assumed running here; waking it is the MCU's job
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      resume_cnt <= 32'h0;
      resume_out <= 1'b0;
    end else if (resume_cnt != 32'h0) begin
      resume_cnt <= resume_cnt - 32'h1;
      resume_out <= (resume_cnt != 32'h1);
    end else if (take_cmd && req_data_in == `CMD_RESUME && suspended_in) begin
      resume_cnt <= 32'(RESUME_CYCLES); // see R12 R13
      resume_out <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Read data buffer
  // ------------------------------------------------------------------
  two_entry_buffer u_rd_buf (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .in_valid_in(take_rd),
    .in_data_in(push_data),
    .in_ready_out(push_ready),
    .out_valid_out(rd_valid_out),
    .out_data_out(rd_data_out),
    .out_ready_in(rd_ready_in)
  );

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);

  AST_SETUP_STALL: assert property ( // see R07
    usb_setup_in |=> !stall_out[0])
    else $error("Stall on endpoint zero survived SETUP");
  AST_SETUP_FLUSH: assert property ( // see R09
    usb_setup_in |=> !buf_full_out[1] && setup_lock)
    else $error("SETUP did not flush IN and lock");
  AST_LOCK_BLOCKS: assert property ( // see R09
    setup_lock && ctrl_sel && take_cmd && req_data_in == `CMD_VALIDATE
    && !usb_rx_done_in && !usb_tx_done_in && !usb_setup_in
    |=> buf_full_out[$past(sel)] == $past(buf_full_out[sel]))
    else $error("Validate acted while locked");
  AST_VALIDATE: assert property ( // see R05
    !setup_lock && take_cmd && req_data_in == `CMD_VALIDATE
    && !usb_tx_done_in && !usb_setup_in |=> buf_full_out[$past(sel)])
    else $error("Validate did not set full flag");
  AST_STALL_SET: assert property ( // see R06
    take_wr && phase == ST_EPST && req_data_in[0] && !usb_setup_in
    |=> stall_out[$past(sel)] && data0_reset_out == 16'h0000)
    else $error("Stall enable not applied");
  AST_UNSTALL: assert property ( // see R08
    take_wr && phase == ST_EPST && !req_data_in[0]
    |=> !stall_out[$past(sel)] && data0_reset_out[$past(sel)])
    else $error("Unstall did not reinitialise endpoint");
  AST_PTR_RESTART: assert property ( // see R19
    take_cmd && req_data_in == `CMD_BUFFER && !primed |=> ptr == 7'h00)
    else $error("Buffer pointer did not restart");
  AST_PTR_STEP: assert property ( // see R02
    buf_acc && !take_cmd |=> ptr == $past(ptr) + 7'h01)
    else $error("Buffer pointer did not advance");
  AST_PRIME_DEFAULT: assert property ( // see R15
    take_rd && phase == ST_IRQ && held && !buf_irq_mode && irq_cnt == 3'h1
    |=> primed)
    else $error("Not primed after two interrupt bytes");
  AST_PRIME_NOT_EARLY: assert property ( // see R16
    take_rd && phase == ST_IRQ && !primed && buf_irq_mode && irq_cnt == 3'h1
    |=> !primed)
    else $error("Primed early in four-byte mode");
  AST_RESUME: assert property ( // see R12
    $rose(resume_out) |-> resume_out [*8])
    else $error("Resume pulse too short");
  AST_FRAME: assert property ( // see R11
    usb_sof_in |=> frame == $past(usb_frame_in))
    else $error("Frame number not captured");

  COV_RESUMED: cover property (primed ##[1:20] buf_acc);
  COV_ACK_BOTH: cover property (setup_lock ##[1:50] !setup_lock);
  COV_STALL: cover property (take_wr && phase == ST_EPST);
  COV_BACKPRESSURE: cover property (!push_ready && req_valid_in);

endmodule

// *** tb/tb.sv ***
// Purpose: Self-checking bench for the endpoint command handler
// Assumes: Short resume count; inputs change 1 ns after the edge
// Notes: Each request waits a cycle first so no input is set twice
`timescale 1ns/100ps
`include "usb_cmd_cfg.svh"
module tb;
  import usb_cmd_pkg::*;
  localparam int RES = 20;
  logic mclk_in = 0;
  logic srst_in = 1;
  logic req_valid_in = 0, req_cmd_in = 0, req_write_in = 0, rd_ready_in = 1;
  byte_t req_data_in = 8'h00;
  logic enhanced_mode_in = 0, suspended_in = 0;
  logic req_ready_out, rd_valid_out, resume_out;
  byte_t rd_data_out, usb_rd_data_out, v, wr_data;
  logic setup, sof, wr, rx_done, tx_done;
  logic [10:0] frame;
  ep_t wr_ep, ep;
  logic [6:0] wr_addr, rd_addr;
  logic [15:0] buf_full_out, stall_out, data0_reset_out;
  int errors = 0, comparisons = 0, res_cnt = 0, n;
  logic d0_seen = 0;
  always #5 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    if (data0_reset_out[3] === 1'b1) d0_seen <= 1'b1;
    if (resume_out === 1'b1) res_cnt <= res_cnt + 1;
  end
  usb_endpoint_command_handler #(.RESUME_CYCLES(RES)) uut (
    .mclk_in(mclk_in), .srst_in(srst_in), .req_valid_in(req_valid_in),
    .req_cmd_in(req_cmd_in), .req_write_in(req_write_in),
    .req_data_in(req_data_in), .req_ready_out(req_ready_out),
    .rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out),
    .rd_ready_in(rd_ready_in), .enhanced_mode_in(enhanced_mode_in),
    .suspended_in(suspended_in), .irq_reg_in(32'hd4c3b2a1),
    .usb_setup_in(setup), .usb_sof_in(sof), .usb_frame_in(frame),
    .usb_wr_in(wr), .usb_wr_ep_in(wr_ep), .usb_wr_addr_in(wr_addr),
    .usb_wr_data_in(wr_data), .usb_rx_done_in(rx_done),
    .usb_tx_done_in(tx_done), .usb_ep_in(ep), .usb_rd_addr_in(rd_addr),
    .usb_rd_data_out(usb_rd_data_out), .buf_full_out(buf_full_out),
    .stall_out(stall_out), .data0_reset_out(data0_reset_out),
    .resume_out(resume_out));
  usb_host_model h (
    .mclk_in(mclk_in), .setup_out(setup), .sof_out(sof), .frame_out(frame),
    .wr_out(wr), .wr_ep_out(wr_ep), .wr_addr_out(wr_addr),
    .wr_data_out(wr_data), .rx_done_out(rx_done), .tx_done_out(tx_done),
    .ep_out(ep), .rd_addr_out(rd_addr), .rd_data_in(usb_rd_data_out));
  // ------------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------------
  task automatic wrap_up();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick();
    @(posedge mclk_in);
    #1;
  endtask
  task automatic req(input logic c, input logic w, input byte_t d);
    int i;
    tick();
    req_valid_in = 1'b1;
    req_cmd_in = c;
    req_write_in = w;
    req_data_in = d;
    for (i = 0; i < 50 && req_ready_out !== 1'b1; i++) tick();
    if (i == 50) begin
      errors++;
      wrap_up();
    end
    tick();
    req_valid_in = 1'b0;
  endtask
  // Commands act without answer; one spare cycle lets flags land
  task automatic cmd(input byte_t d);
    req(1'b1, 1'b0, d);
    tick();
  endtask
  task automatic wrb(input byte_t d);
    req(1'b0, 1'b1, d);
  endtask
  task automatic wait_rd(output byte_t b);
    int i;
    for (i = 0; i < 50 && rd_valid_out !== 1'b1; i++) tick();
    if (i == 50) begin
      errors++;
      wrap_up();
    end
    b = rd_data_out;
    tick();
  endtask
  task automatic rdx(input byte_t exp);
    byte_t b;
    req(1'b0, 1'b0, 8'h00);
    wait_rd(b);
    chk(16'(b), 16'(exp));
  endtask
  // ------------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge mclk_in);
    #1;
    srst_in = 0;
    chk({req_ready_out, rd_valid_out, resume_out}, 16'h4);
    chk(stall_out | buf_full_out, 16'h0);
    cmd(`CMD_FRAME);
    rdx(8'h00);
    rdx(8'h00);
    h.put_pkt(4'h2, '{8'h00, 8'h02, 8'ha5, 8'h5a});
    cmd(8'h02);
    rdx(8'h01);
    cmd(`CMD_BUFFER);
    rdx(8'h00);
    rdx(8'h02);
    rdx(8'ha5);
    rdx(8'h5a);
    cmd(`CMD_CLEAR_BUF);
    chk(16'(buf_full_out[2]), 16'h0);
    cmd(8'h03);
    cmd(`CMD_BUFFER);
    wrb(8'h00);
    wrb(8'h01);
    wrb(8'h77);
    cmd(`CMD_VALIDATE);
    chk(16'(buf_full_out[3]), 16'h1);
    h.get_in(4'h3, 7'h02, v);
    chk(16'(v), 16'h77);
    cmd(8'h43);
    wrb(8'h01);
    tick();
    chk(stall_out, 16'h0008);
    cmd(8'h83);
    rdx(8'ha0);
    d0_seen = 1'b0;
    cmd(8'h43);
    wrb(8'h00);
    tick();
    chk({stall_out[3], buf_full_out[3], d0_seen}, 16'h1);
    // Setup lock: endpoint zero stalled, one validated, then SETUP
    cmd(8'h40);
    wrb(8'h01);
    cmd(8'h01);
    cmd(`CMD_BUFFER);
    wrb(8'h00);
    wrb(8'h00);
    cmd(`CMD_VALIDATE);
    chk({stall_out[0], buf_full_out[1]}, 16'h3);
    h.setup();
    tick();
    chk({stall_out[0], buf_full_out[1]}, 16'h0);
    cmd(`CMD_VALIDATE);
    chk(16'(buf_full_out[1]), 16'h0);
    cmd(`CMD_ACK_SETUP);
    cmd(8'h00);
    cmd(`CMD_ACK_SETUP);
    cmd(8'h01);
    cmd(`CMD_VALIDATE);
    chk(16'(buf_full_out[1]), 16'h1);
    h.tx_done(4'h1);
    chk(16'(buf_full_out[1]), 16'h0);
    h.sof(11'h5a3);
    cmd(`CMD_FRAME);
    rdx(8'ha3);
    rdx(8'h05);
    // Resume: refused while awake, fixed length when suspended
    res_cnt = 0;
    cmd(`CMD_RESUME);
    chk(16'(resume_out), 16'h0);
    suspended_in = 1'b1;
    cmd(`CMD_RESUME);
    repeat (RES + 10) tick();
    chk(16'(res_cnt), 16'(RES));
    suspended_in = 1'b0;
    // Interrupted transfer, default then enhanced priming
    h.put_pkt(4'h4, '{8'h00, 8'h03, 8'h11, 8'h22, 8'h33});
    cmd(8'h04);
    cmd(`CMD_BUFFER);
    rdx(8'h00);
    rdx(8'h03);
    cmd(`CMD_READ_IRQ);
    rdx(8'ha1);
    rdx(8'hb2);
    rdx(8'h11);
    enhanced_mode_in = 1'b1;
    cmd(`CMD_BUF_IRQ_MODE);
    cmd(`CMD_BUFFER);
    rdx(8'h00);
    cmd(`CMD_READ_IRQ);
    rdx(8'ha1);
    rdx(8'hb2);
    rdx(8'hc3);
    rdx(8'hd4);
    rdx(8'h03);
    cmd(8'h44);
    rdx(8'h00);
    rdx(8'h11);
    // Stalled drain: two bytes held, then refused, none lost
    cmd(`CMD_BUFFER);
    rd_ready_in = 1'b0;
    for (n = 0; n < 8; n++) begin
      tick();
      tick();
      if (req_ready_out !== 1'b1) break;
      req(1'b0, 1'b0, 8'h00);
    end
    chk(16'(n), 16'h2);
    rd_ready_in = 1'b1;
    wait_rd(v);
    chk(16'(v), 16'h00);
    wait_rd(v);
    chk(16'(v), 16'h03);
    wrap_up();
  end
endmodule

// *** tb/usb_host_model.sv ***
// Purpose: Packet engine and host side stand-in for the command handler
// Assumes: Tasks are called from tb, acting 1 ns after a rising edge
// Notes: Released data lines show the inverse of the last value
`timescale 1ns/100ps
module usb_host_model (
  // Clock
  input wire logic mclk_in,
  // Engine side
  output logic setup_out,
  output logic sof_out,
  output logic [10:0] frame_out,
  output logic wr_out,
  output usb_cmd_pkg::ep_t wr_ep_out,
  output logic [6:0] wr_addr_out,
  output usb_cmd_pkg::byte_t wr_data_out,
  output logic rx_done_out,
  output logic tx_done_out,
  output usb_cmd_pkg::ep_t ep_out,
  output logic [6:0] rd_addr_out,
  input wire usb_cmd_pkg::byte_t rd_data_in
);
  import usb_cmd_pkg::*;
  initial begin
    {setup_out, sof_out, wr_out, rx_done_out, tx_done_out} = 5'h00;
    {frame_out, wr_ep_out, wr_addr_out, wr_data_out} = 30'h0;
    {ep_out, rd_addr_out} = 11'h000;
  end
  task automatic tick();
    @(posedge mclk_in);
    #1;
  endtask
  // Length high, length low, payload, one byte a cycle
  task automatic put_pkt(input ep_t ep, input byte_t b[$]);
    for (int i = 0; i < b.size(); i++) begin
      tick();
      wr_out = 1'b1;
      wr_ep_out = ep;
      wr_addr_out = 7'(i);
      wr_data_out = b[i];
    end
    tick();
    wr_out = 1'b0;
    wr_data_out = ~wr_data_out;
    ep_out = ep;
    rx_done_out = 1'b1;
    tick();
    rx_done_out = 1'b0;
  endtask
  task automatic sof(input logic [10:0] f);
    tick();
    frame_out = f;
    sof_out = 1'b1;
    tick();
    sof_out = 1'b0;
    frame_out = ~f;
  endtask
  task automatic setup();
    tick();
    setup_out = 1'b1;
    tick();
    setup_out = 1'b0;
  endtask
  task automatic get_in(input ep_t ep, input logic [6:0] a, output byte_t v);
    tick();
    ep_out = ep;
    rd_addr_out = a;
    tick();
    v = rd_data_in;
  endtask
  task automatic tx_done(input ep_t ep);
    tick();
    ep_out = ep;
    tx_done_out = 1'b1;
    tick();
    tx_done_out = 1'b0;
  endtask
endmodule
